// [txu_consts.svh]
/*
  Constants for the transmit element payload unpacker: field positions,
  word counts and length decode limits.
  Assumes it is included by its bare name from the unpacker design file.
*/
`ifndef TXU_CONSTS_SVH
`define TXU_CONSTS_SVH

// ==========================================================
// Element layout
`define TXU_LEN_CODE_HI 19
`define TXU_LEN_CODE_LO 16
`define TXU_DATA_WORD_MIN 2
`define TXU_DATA_WORD_MAX 16
`define TXU_FIFO_DEPTH 4

// ==========================================================
// Length decode
`define TXU_CLASSIC_MAX_LEN 8
`define TXU_DIRECT_CODE_MAX 8

`endif

// [txu_pkg.sv]
/*
  Types shared by the transmit element payload unpacker, its checker and the bench.
  Assumes txu_consts.svh holds the numeric constants.
*/
package txu_pkg;

  // One payload byte leaving the unpacker.
  typedef struct packed {
    logic [7:0] data;
    logic [5:0] index;
    logic last;
  } pay_byte_s;

  // Element header presented by the transmit engine.
  typedef struct packed {
    logic [31:0] ctrl_word;
    logic fd_format;
    logic [4:0] word_count;
  } elem_hdr_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_EMIT = 2'b10
  } unpack_state_e;

endpackage

// [txu_fifo.sv]
/*
  Small flip-flop FIFO with valid and ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module txu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] rd_r, rd_nxt, wr_r, wr_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  // Advances a pointer with wrap at the depth.
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // ==========================================================
  // Next state
  // Full and empty come straight from the occupancy count.
  always_comb begin
    in_ready = (cnt_r != (AW+1)'(DEPTH));
    out_valid = (cnt_r != '0);
    out_data = mem_r[rd_r];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    mem_nxt = mem_r;
    if (push) begin
      mem_nxt[wr_r] = in_data;
    end
    wr_nxt = push ? bump(wr_r) : wr_r;
    rd_nxt = pop ? bump(rd_r) : rd_r;
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = (AW+1)'(cnt_r + 1'b1);
    end else if (pop && !push) begin
      cnt_nxt = (AW+1)'(cnt_r - 1'b1);
    end
  end

  // Registers the pointers, count and storage.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_r <= '0;
      wr_r <= '0;
      cnt_r <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      cnt_r <= cnt_nxt;
      mem_r <= mem_nxt;
    end
  end

endmodule

`default_nettype wire

// [tx_buffer_payload_unpacker.sv]
/*
  Transmit element payload unpacker: decodes the length code of a transmit
  element and streams its payload bytes, in order, through a small FIFO.
  Assumes the transmit engine presents the element control word and then
  supplies data words on request; one clock, synchronous active-low reset.
*/
// Notes on behaviour
// R1: Length code is control word bits 19:16.
// R2: Codes zero to eight give that byte count.
// R3: Classic frames cap codes nine up at eight.
// R4: FD codes nine up: 12,16,20,24,32,48,64.
// R5: First data word holds bytes 0-3, low first.
// R6: Second data word: bytes 7,6,5 high octets.
// R7: Byte 4 lowest; later words same pattern.
// R8: Element size gives two to sixteen data words.
// R9: Emit only decoded bytes; ignore extra storage.
`timescale 1ns/1ps
`default_nettype none
`include "txu_consts.svh"

module tx_buffer_payload_unpacker #(
  parameter int FIFO_DEPTH = `TXU_FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Element start from the transmit engine.
  input wire logic start_valid,
  output logic start_ready,
  input wire txu_pkg::elem_hdr_s start_hdr,
  // Data word fetch from message storage.
  output logic word_req,
  output logic [3:0] word_idx,
  input wire logic word_valid,
  input wire logic [31:0] word_data,
  // Payload byte stream to the frame serialiser.
  output logic byte_valid,
  input wire logic byte_ready,
  output txu_pkg::pay_byte_s byte_out,
  // Status.
  output logic [6:0] payload_len,
  output logic busy
);
  import txu_pkg::*;

  // ==========================================================
  // Length decode
  // Turns a length code and the frame format into a byte count.
  function automatic logic [6:0] decode_len(input logic [3:0] code,
                                            input logic fd);
    logic [6:0] n;
    n = 7'h00;
    if (code <= 4'(`TXU_DIRECT_CODE_MAX)) begin
      n = {3'h0, code}; // R2
    end else if (!fd) begin
      n = 7'(`TXU_CLASSIC_MAX_LEN); // R3
    end else begin
      case (code) // R4
        4'h9: n = 7'h0c;
        4'ha: n = 7'h10;
        4'hb: n = 7'h14;
        4'hc: n = 7'h18;
        4'hd: n = 7'h20;
        4'he: n = 7'h30;
        default: n = 7'h40;
      endcase
    end
    decode_len = n;
  endfunction

  unpack_state_e state_r, state_nxt;
  logic [6:0] len_r, len_nxt;
  logic [6:0] pos_r, pos_nxt;
  logic [31:0] word_r, word_nxt;
  logic rdy_r, rdy_nxt;
  logic req_r, req_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic busy_r, busy_nxt;
  logic [6:0] plen_r, plen_nxt;
  logic [3:0] code;
  logic [4:0] wsize;
  logic [6:0] cap;
  logic f_in_valid, f_in_ready;
  pay_byte_s f_in_data, f_out_data;
  logic f_out_valid;
  logic ov_r, ov_nxt;
  pay_byte_s ob_r, ob_nxt;

  // ==========================================================
  // Control sequence
  // Captures the header, fetches each data word that holds decoded bytes and splits it into bytes.
  always_comb begin
    code = start_hdr.ctrl_word[`TXU_LEN_CODE_HI:`TXU_LEN_CODE_LO]; // R1
    wsize = start_hdr.word_count;
    if (wsize < 5'(`TXU_DATA_WORD_MIN)) begin
      wsize = 5'(`TXU_DATA_WORD_MIN); // R8
    end else if (wsize > 5'(`TXU_DATA_WORD_MAX)) begin
      wsize = 5'(`TXU_DATA_WORD_MAX); // R8
    end
    cap = {wsize, 2'b00};
    state_nxt = state_r;
    len_nxt = len_r;
    pos_nxt = pos_r;
    word_nxt = word_r;
    req_nxt = 1'b0;
    idx_nxt = idx_r;
    plen_nxt = plen_r;
    f_in_valid = 1'b0;
    f_in_data.data = word_r[8*pos_r[1:0] +: 8]; // R5 R6 R7
    f_in_data.index = pos_r[5:0];
    f_in_data.last = (7'(pos_r + 1'b1) == len_r);
    case (state_r)
      ST_IDLE: begin
        if (start_valid) begin
          len_nxt = decode_len(code, start_hdr.fd_format);
          if (len_nxt > cap) begin
            len_nxt = cap; // R8
          end
          plen_nxt = len_nxt;
          pos_nxt = 7'h00;
          idx_nxt = 4'h0;
          if (len_nxt != 7'h00) begin
            req_nxt = 1'b1;
            state_nxt = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        if (word_valid) begin
          word_nxt = word_data;
          state_nxt = ST_EMIT;
        end else begin
          req_nxt = 1'b1;
        end
      end
      ST_EMIT: begin
        f_in_valid = 1'b1;
        if (f_in_ready) begin
          pos_nxt = 7'(pos_r + 1'b1);
          if (f_in_data.last) begin
            state_nxt = ST_IDLE; // R9
          end else if (pos_r[1:0] == 2'b11) begin
            idx_nxt = 4'(idx_r + 1'b1);
            req_nxt = 1'b1;
            state_nxt = ST_FETCH;
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // A byte entering the FIFO on this edge still counts as pending.
    busy_nxt = (state_nxt != ST_IDLE) || f_in_valid || f_out_valid ||
               ov_nxt;
    // The start handshake is ready exactly when the sequence is idle.
    rdy_nxt = (state_nxt == ST_IDLE);
  end

  // Registers the sequence state.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      len_r <= 7'h00;
      pos_r <= 7'h00;
      word_r <= 32'h0000_0000;
      rdy_r <= 1'b1;
      req_r <= 1'b0;
      idx_r <= 4'h0;
      busy_r <= 1'b0;
      plen_r <= 7'h00;
    end else begin
      state_r <= state_nxt;
      len_r <= len_nxt;
      pos_r <= pos_nxt;
      word_r <= word_nxt;
      rdy_r <= rdy_nxt;
      req_r <= req_nxt;
      idx_r <= idx_nxt;
      busy_r <= busy_nxt;
      plen_r <= plen_nxt;
    end
  end

  // ==========================================================
  // Byte buffer and output stage
  txu_fifo #(
    .WIDTH($bits(pay_byte_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in_data),
    .out_valid(f_out_valid),
    .out_ready(!ov_r || byte_ready),
    .out_data(f_out_data)
  );

  // Output register so every output comes from a flip-flop.
  always_comb begin
    ov_nxt = ov_r;
    ob_nxt = ob_r;
    if (!ov_r || byte_ready) begin
      ov_nxt = f_out_valid;
      ob_nxt = f_out_valid ? f_out_data : ob_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ov_r <= 1'b0;
      ob_r <= '0;
    end else begin
      ov_r <= ov_nxt;
      ob_r <= ob_nxt;
    end
  end

  assign byte_valid = ov_r;
  assign byte_out = ob_r;
  assign word_req = req_r;
  assign word_idx = idx_r;
  assign payload_len = plen_r;
  assign busy = busy_r;
  assign start_ready = rdy_r;

endmodule

`default_nettype wire

// [txu_asserts.sv]
/*
  Port checker for the transmit element payload unpacker.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module txu_asserts #(
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Element start.
  input wire logic start_valid,
  input wire logic start_ready,
  input wire txu_pkg::elem_hdr_s start_hdr,
  // Word fetch.
  input wire logic word_req,
  input wire logic [3:0] word_idx,
  input wire logic word_valid,
  input wire logic [31:0] word_data,
  // Byte stream and status.
  input wire logic byte_valid,
  input wire logic byte_ready,
  input wire txu_pkg::pay_byte_s byte_out,
  input wire logic [6:0] payload_len,
  input wire logic busy
);
  import txu_pkg::*;
  logic take;
  logic [3:0] code;
  logic [6:0] lim;
  // ==========================================================
  // Helpers
  function automatic logic [6:0] min7(logic [6:0] a, logic [6:0] b);
    return (a < b) ? a : b;
  endfunction
  function automatic logic [6:0] fd_len(logic [3:0] c);
    case (c)
      4'h9: return 7'h0c;
      4'ha: return 7'h10;
      4'hb: return 7'h14;
      4'hc: return 7'h18;
      4'hd: return 7'h20;
      4'he: return 7'h30;
      default: return 7'h40;
    endcase
  endfunction
  // Header take, its length code and the storage limit in bytes.
  assign take = start_valid && start_ready;
  assign code = start_hdr.ctrl_word[19:16];
  assign lim = (start_hdr.word_count < 5'h02) ? 7'h08 :
    (start_hdr.word_count > 5'h10) ? 7'h40 : {start_hdr.word_count, 2'h0};
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_len_direct: assert property (take && code <= 4'h8 |=>
    payload_len == min7({3'h0, $past(code)}, $past(lim)))
    else $error("direct length wrong");
  a_len_classic: assert property (take && code > 4'h8 &&
    !start_hdr.fd_format |=> payload_len == min7(7'h08, $past(lim)))
    else $error("classic length not capped");
  a_len_fd: assert property (take && code > 4'h8 &&
    start_hdr.fd_format |=>
    payload_len == min7(fd_len($past(code)), $past(lim)))
    else $error("fd length wrong");
  a_first_req: assert property (take && code != 4'h0 |=>
    word_req && word_idx == 4'h0) else $error("first fetch wrong");
  a_zero_quiet: assert property (take && code == 4'h0 |=>
    !word_req [*4]) else $error("fetch for empty payload");
  a_req_bound: assert property (word_req |->
    {word_idx, 2'h0} < payload_len) else $error("fetch past length");
  a_idx_steady: assert property ((word_req && !word_valid) ##1
    word_req |-> $stable(word_idx)) else $error("index moved");
  a_byte_hold: assert property (byte_valid && !byte_ready |=>
    byte_valid && $stable(byte_out)) else $error("byte dropped");
  a_busy_take: assert property (take && code != 4'h0 |=>
    busy && !start_ready) else $error("not busy after start");
  c_fd_max: cover property (take && start_hdr.fd_format && code == 4'hf);
  c_stall: cover property (byte_valid && !byte_ready [*8]);
  c_empty: cover property (take && code == 4'h0);
endmodule
`default_nettype wire

// [txu_store_model.sv]
/*
  Message storage model answering data word requests.
  Assumes the unpacker's fetch port and one clock.
*/
`timescale 1ns/1ps
`default_nettype none
module txu_store_model (
  // Clock, reset and pace.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  // Word fetch.
  input wire logic word_req,
  input wire logic [3:0] word_idx,
  output logic word_valid,
  output logic [31:0] word_data
);
  logic pend;
  logic [3:0] idx;
  logic [1:0] wait_cnt;
  // Serves one request at a time; idle data flips so it never looks valid.
  always @(posedge clk) begin
    word_valid <= 1'b0;
    word_data <= ~word_data;
    if (!rst_b) begin
      pend <= 1'b0;
      word_data <= 32'h0f0f0f0f;
    end else if (pend && wait_cnt == 2'h0) begin
      pend <= 1'b0;
      word_valid <= 1'b1;
      for (int b = 0; b < 4; b++) begin
        word_data[8*b +: 8] <= {2'h0, idx, 2'(b)} ^ 8'ha5;
      end
    end else if (pend) begin
      wait_cnt <= wait_cnt - 2'h1;
    end else if (word_req && !word_valid) begin
      pend <= 1'b1;
      idx <= word_idx;
      wait_cnt <= slow ? 2'h3 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
/*
  Self-checking bench for the transmit element payload unpacker.
  Assumes the storage model and the checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import txu_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, slow = 1'b0;
  logic start_valid = 1'b0, start_ready, word_req, word_valid;
  logic byte_valid, byte_ready = 1'b0, busy;
  logic [3:0] word_idx;
  logic [31:0] word_data;
  logic [6:0] payload_len;
  elem_hdr_s start_hdr = '0;
  pay_byte_s byte_out;
  int error_cnt = 0, checks = 0, cyc = 0;
  tx_buffer_payload_unpacker #(.FIFO_DEPTH(4)) u_tx_buffer_payload_unpacker (
    .clk, .rst_b, .start_valid, .start_ready, .start_hdr, .word_req,
    .word_idx, .word_valid, .word_data, .byte_valid, .byte_ready,
    .byte_out, .payload_len, .busy);
  txu_store_model u_txu_store_model (.clk, .rst_b, .slow, .word_req,
    .word_idx, .word_valid, .word_data);
  // ==========================================================
  // Clock, watchdog and shared tasks
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  function automatic logic [6:0] exp_len(logic [3:0] c, logic fd,
      logic [4:0] wc);
    logic [6:0] n, lim;
    logic [6:0] tab [7] = '{7'h0c, 7'h10, 7'h14, 7'h18, 7'h20, 7'h30, 7'h40};
    n = (c <= 4'h8) ? {3'h0, c} : (fd ? tab[c - 4'h9] : 7'h08);
    lim = (wc < 5'h02) ? 7'h08 : (wc > 5'h10) ? 7'h40 : {wc, 2'h0};
    return (n < lim) ? n : lim;
  endfunction
  // One element: start, a refused second start if the length is nonzero, then every byte judged.
  task automatic run_elem(input logic [3:0] c, input logic fd,
      input logic [4:0] wc, input int stall);
    logic [6:0] n;
    int k, t;
    n = exp_len(c, fd, wc);
    k = 0;
    t = 0;
    chk(start_ready, 1'b1);
    start_hdr = '{ctrl_word: 32'hfff0ffff | {12'h0, c, 16'h0},
      fd_format: fd, word_count: wc};
    start_valid = 1'b1;
    @(posedge clk);
    #1 start_hdr.ctrl_word[19:16] = ~c;
    start_valid = (n != 7'h0);
    @(posedge clk);
    #1 start_valid = 1'b0;
    chk(payload_len, n);
    // Each byte is judged off the edge, before the edge that accepts it.
    while (k < n && t < 2000) begin
      byte_ready = (t >= stall);
      if (byte_valid && byte_ready) begin
        chk(byte_out.data, 8'(k) ^ 8'ha5);
        chk(byte_out.index, k);
        chk(byte_out.last, k == n - 1);
        k++;
      end
      @(posedge clk);
      #1 t++;
    end
    chk(k, n);
    byte_ready = 1'b1;
    repeat (8) @(posedge clk);
    #1 chk(byte_valid, 1'b0);
    chk(busy, 1'b0);
    byte_ready = 1'b0;
  endtask
  // ==========================================================
  // Scenarios
  task automatic s_codes();
    for (int f = 0; f < 2; f++) begin
      for (int c = 0; c < 16; c++) begin
        slow = c[0];
        run_elem(4'(c), f[0], 5'h10, (c == 15) ? 20 : c % 3);
      end
    end
  endtask
  task automatic s_small_elem();
    run_elem(4'hf, 1'b1, 5'h02, 0);
    run_elem(4'hd, 1'b1, 5'h05, 3);
    run_elem(4'h8, 1'b0, 5'h02, 0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_b = 1'b1;
    s_codes();
    s_small_elem();
    wrap_up();
  end
endmodule
bind tx_buffer_payload_unpacker txu_asserts #(.FIFO_DEPTH(FIFO_DEPTH))
  u_txu_asserts (.clk, .rst_b, .start_valid, .start_ready, .start_hdr,
  .word_req, .word_idx, .word_valid, .word_data, .byte_valid,
  .byte_ready, .byte_out, .payload_len, .busy);
`default_nettype wire
